// ---- core/efd_pkg.sv ----
/*
  Constants and carrier types for the edge frequency divider.
  Assumes a single system clock and that every user of it writes efd_pkg::name.
*/
`default_nettype none

package efd_pkg;

  // ---------------------------------------------------------------
  // Defaults and lower limits of the divider settings
  // ---------------------------------------------------------------
  localparam int EFD_DIV_DEFAULT = 2;
  localparam int EFD_DIV_MIN = 1;
  localparam int EFD_HIGH_DEFAULT = 1;
  localparam int EFD_HIGH_MIN = 1;
  localparam int EFD_START_DEFAULT = 0;
  localparam int EFD_CNT_W_DEFAULT = 16;

  // ---------------------------------------------------------------
  // Counter landmarks and reset values
  // ---------------------------------------------------------------
  localparam int EFD_FIRST_HIGH_COUNT = 1;
  localparam logic EFD_PREV_IN_RESET = 1'b1;
  localparam logic EFD_ADV_RESET = 1'b0;

  // Outputs of the divider, all registered.
  typedef struct packed {
    logic div_out;
    logic advanced;
  } efd_status_t;

endpackage

`default_nettype wire

// ---- core/efd_divider.sv ----
/*
  Edge frequency divider: counts rising edges of freq_in and drives a divided output.
  Assumes freq_in is synchronous to ref_clk and stays at least one cycle high and one low.
*/
// Notes on behaviour
// - The counter only moves on a rising edge of the input; falling edges change neither the counter nor the output.
// - The ratio defaults to 2 and is at least 1; the output repeats every that many edges.
// - The high span defaults to 1 and is at least 1; the output is high for that many counted edges.
// - The counter holds the start count, default 0, before the first input edge.
// - The output first goes high when the counter reaches 1, also after a wrap past the ratio.
// - A start count of N below 1 delays the first rise until rising edge 1-N, also for negative N.
`timescale 1ns/1ps
`default_nettype none

module efd_divider #(
  parameter int DIV_FACTOR = efd_pkg::EFD_DIV_DEFAULT,
  parameter int HIGH_CYCLES = efd_pkg::EFD_HIGH_DEFAULT,
  parameter int START_COUNT = efd_pkg::EFD_START_DEFAULT,
  parameter int CNT_W = efd_pkg::EFD_CNT_W_DEFAULT
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic freq_in,
  output var efd_pkg::efd_status_t status
);

  // ---------------------------------------------------------------
  // Settings at counter width
  // ---------------------------------------------------------------
  localparam logic signed [CNT_W-1:0] DIV_C = signed'(CNT_W'(DIV_FACTOR));
  localparam logic signed [CNT_W-1:0] HIGH_C = signed'(CNT_W'(HIGH_CYCLES));
  localparam logic signed [CNT_W-1:0] START_C = signed'(CNT_W'(START_COUNT));
  localparam logic signed [CNT_W-1:0] ONE_C = signed'(CNT_W'(efd_pkg::EFD_FIRST_HIGH_COUNT));
  localparam logic OUT_RESET = (START_COUNT >= efd_pkg::EFD_FIRST_HIGH_COUNT)
                               && (START_COUNT <= HIGH_CYCLES);

  // The start count may not lie beyond the ratio, since the wrap only fires on equality.
  if (DIV_FACTOR < efd_pkg::EFD_DIV_MIN || HIGH_CYCLES < efd_pkg::EFD_HIGH_MIN
      || HIGH_CYCLES > DIV_FACTOR || START_COUNT > DIV_FACTOR || CNT_W < 2 || CNT_W > 31
      || DIV_FACTOR >= (1 << (CNT_W - 1)) || START_COUNT < -(1 << (CNT_W - 1)))
  begin : g_bad_settings
    $error("efd_divider: settings outside what the counter can serve");
  end

  // ---------------------------------------------------------------
  // Edge detection and counting
  // ---------------------------------------------------------------
  logic prev_in;
  logic signed [CNT_W-1:0] cnt;
  logic div_out;
  logic advanced;

  // The counter walks up from the start count to the ratio and then restarts at one, so
  // after its first wrap it only takes the values one to the ratio. The output is high
  // while the counter lies between one and the high span, which sets the duty cycle.
  // Wrapping on equality keeps the compare narrow, at the cost of refusing a start count
  // above the ratio, which would never meet the wrap value.

  // Only a low-to-high step of the input counts; a high held at reset release does not.
  wire rise = freq_in & ~prev_in;
  wire step_now = clk_en & rise;
  wire at_wrap = (cnt == DIV_C);
  wire signed [CNT_W-1:0] cnt_inc = cnt + ONE_C;
  wire signed [CNT_W-1:0] next_cnt = at_wrap ? ONE_C : cnt_inc;
  wire next_high = (next_cnt >= ONE_C) && (next_cnt <= HIGH_C);

  // The history flop freezes with the rest, so an input that rises while the enable is low
  // is counted once the enable returns, as long as the input is still high then.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      prev_in <= efd_pkg::EFD_PREV_IN_RESET;
    end
    else if (clk_en)
    begin
      prev_in <= freq_in;
    end
  end

  // A negative start count simply takes more edges to climb to one; no extra state is kept.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt <= START_C;
    end
    else if (step_now)
    begin
      cnt <= next_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // The level is worked out from the next count, so it changes on the very edge that
  // moves the counter rather than one cycle later.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_out <= OUT_RESET;
    end
    else if (step_now)
    begin
      div_out <= next_high;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      advanced <= efd_pkg::EFD_ADV_RESET;
    end
    else if (clk_en)
    begin
      advanced <= rise;
    end
  end

  assign status = '{div_out: div_out, advanced: advanced};

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Each implication over a counting step also asks for reset low in its first cycle: the disable condition sees
  // the reset input only after it has changed, so a one-cycle reset pulse would otherwise
  // be judged as an ordinary counting step.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  localparam logic [CNT_W-1:0] HIGH_U = HIGH_C;

  // Counted edges seen while the output stands high. It saturates at the high span, which
  // is enough to show a span that runs too long.
  logic [CNT_W-1:0] high_edges;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      high_edges <= '0;
    end
    else if (clk_en && !div_out)
    begin
      high_edges <= '0;
    end
    else if (step_now && high_edges < HIGH_U)
    begin
      high_edges <= high_edges + CNT_W'(1);
    end
  end

  // The output is judged against the count of the same cycle or the cycle before, never against next_high.
  falling_no_change_a: assert property (
    !srst && !step_now |=> $stable(cnt) && $stable(div_out))
    else $error("counter or output moved without a rising edge");
  ratio_wrap_a: assert property (
    !srst && step_now && at_wrap |=> cnt == ONE_C)
    else $error("counter did not wrap to one after the ratio");
  high_span_a: assert property (
    !srst && step_now |=> div_out == (($past(cnt) == DIV_C)
                                      || ($past(cnt) >= 0 && $past(cnt) < HIGH_C)))
    else $error("output level disagrees with the high span");
  start_load_a: assert property (
    disable iff (1'b0) srst |=> cnt == START_C && div_out == OUT_RESET && !advanced
                                && prev_in)
    else $error("counter not loaded with the start count");
  first_high_a: assert property (
    !$past(srst) && $rose(div_out) |-> cnt == ONE_C && $past(step_now))
    else $error("output rose away from count one");
  edge_step_a: assert property (
    !srst && step_now && !at_wrap |=> cnt == $past(cnt) + ONE_C)
    else $error("counter did not step by one on an edge");
  low_outside_a: assert property (
    (cnt < ONE_C || cnt > HIGH_C) |-> !div_out)
    else $error("output high outside the high span");
  advance_flag_a: assert property (
    !srst && step_now |=> advanced)
    else $error("advance flag missing after an edge");
  advance_quiet_a: assert property (
    !srst && clk_en && !rise |=> !advanced)
    else $error("advance flag raised without an edge");
  enable_freeze_a: assert property (
    !srst && !clk_en |=> $stable(prev_in) && $stable(advanced))
    else $error("state moved while the enable was low");
  history_track_a: assert property (
    !srst && clk_en |=> prev_in == $past(freq_in))
    else $error("input history missed an enabled sample");
  high_limit_a: assert property (
    HIGH_C < DIV_C && div_out |-> high_edges < HIGH_U)
    else $error("output stayed high longer than the high span");
  span_end_a: assert property (
    !srst && step_now && cnt == HIGH_C && HIGH_C < DIV_C |=> !div_out)
    else $error("output still high after the high span");
  count_bound_a: assert property (
    !srst && cnt >= ONE_C |=> cnt >= ONE_C && cnt <= DIV_C)
    else $error("counter left the range one to the ratio");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  // These show that the wrap, a full high span, a negative start, an edge held over a
  // frozen cycle and a long low stretch are all reached.
  wrap_seen_c: cover property (clk_en && rise && at_wrap ##1 div_out);
  full_high_c: cover property ($rose(div_out) ##1 div_out [*2]);
  neg_start_c: cover property (cnt < 0 ##1 cnt == 0);
  held_edge_c: cover property (!clk_en && rise ##1 clk_en && rise);
  long_low_c: cover property (!div_out [*3] ##1 div_out);

endmodule

`default_nettype wire

// ---- sim/efd_src.sv ----
/* Upstream freq_in source; each level stands gap+1 cycles of ref_clk, gap set by the bench. */
`timescale 1ns/1ps
`default_nettype none
module efd_src (
  input wire logic ref_clk,
  input wire logic [1:0] gap,
  output logic freq_in
);
  logic [1:0] held = 2'h0;
  initial freq_in = 1'b0;
  always @(posedge ref_clk)
  begin
    freq_in <= (held >= gap) ? ~freq_in : freq_in;
    held <= (held >= gap) ? 2'h0 : held + 2'h1;
  end
endmodule
`default_nettype wire

// ---- sim/efd_divider_tb_top.sv ----
/* Bench for efd_divider: random edges, enables, resets; efd_src supplies freq_in. */
`timescale 1ns/1ps
`default_nettype none
module efd_divider_tb_top;
  localparam int DIV = 4, HIGH = 2, START = -2;
  logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, freq_in, prv = 1'b1, adv = 1'b0;
  logic [1:0] gap = 2'h0, status;
  logic [15:0] lfsr = 16'hd9c9;
  int n_fail = 0, n_tests = 0, cnt = START;
  always #20 ref_clk = ~ref_clk;
  efd_src efd_src_i (.ref_clk(ref_clk), .gap(gap), .freq_in(freq_in));
  efd_divider #(.DIV_FACTOR(DIV), .HIGH_CYCLES(HIGH), .START_COUNT(START)) efd_divider_i (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .freq_in(freq_in), .status(status));
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Level the output should show for a count, and the counted edge of its first rise.
  function automatic logic want_high(input int c);
    return c >= 1 && c <= HIGH;
  endfunction
  function automatic int first_rise();
    return (START < 1) ? 1 - START : DIV - START + 1;
  endfunction
  // Reference model; an input already high when reset ends is not an edge.
  always @(posedge ref_clk)
  begin
    adv = srst ? 1'b0 : (clk_en ? freq_in & ~prv : adv);
    prv = srst ? 1'b1 : (clk_en ? freq_in : prv);
    cnt = srst ? START : ((adv && clk_en) ? ((cnt == DIV) ? 1 : cnt + 1) : cnt);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    n_fail += int'(seen !== want);
    if (seen !== want)
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
  endtask
  task automatic summarize(input int extra);
    n_fail += extra;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic run(input int n, input string name);
    repeat (n)
    begin
      @(posedge ref_clk);
      lfsr = step(lfsr);
      {srst, clk_en, gap} <= {lfsr[9:4] == 6'h0, lfsr[1:0] != 2'h0, lfsr[3:2]};
      @(negedge ref_clk);
      check(16'(status), 16'({want_high(cnt), adv}));
    end
    $display("test %s done", name);
  endtask
  // Fresh reset at a steady edge rate: the first rise comes on the edge the start count
  // asks for, and three ratios of edges hold exactly three high spans.
  task automatic corner();
    int edges = 0;
    int first = 0;
    int highs = 0;
    @(posedge ref_clk);
    srst <= 1'b1;
    clk_en <= 1'b1;
    gap <= 2'h1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (200)
    begin
      @(negedge ref_clk);
      if (status[0] === 1'b1)
      begin
        edges++;
        if (first == 0 && status[1] === 1'b1)
          first = edges;
        if (first != 0 && edges < first + 3 * DIV && status[1] === 1'b1)
          highs++;
      end
    end
    check(16'(first), 16'(first_rise()));
    check(16'(highs), 16'(3 * HIGH));
    $display("test directed start done");
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    run(1500, "random edges");
    corner();
    summarize(0);
  end
  initial #400000 summarize(1);
endmodule
`default_nettype wire
